// [verilog/fsf_flag_chain.sv]
// FIFO storage with status flags, programmable offsets and depth chain pulses.
//
// How it works
// - Empty goes low while nothing is stored, blocks reads then, and goes high once a word is held.
// - Empty changes only on rising edges of clk_sys, the single clock shared by reads and writes.
// - Almost-empty goes low when the word count is at or below the almost-empty offset.
// - The almost-empty offset resets to 31, 63 or 127 depending on depth.
// - Almost-full goes low when the word count is within the almost-full offset of full.
// - The almost-full offset resets to 31, 63 or 127 depending on depth.
// - Outside depth expansion the shared output is half-full, low above half occupancy.
// - In depth expansion the shared output pulses when the last location is written.
// - In depth expansion the read chain output pulses when the last location is read.
// - Read data leaves on an 18-bit bus as wide as the write data.
// - Full goes low when storage is full, blocks writes, and is synchronous to writes.
// - Reset clears both pointers, sets full and almost-full high, empty and almost-empty low.
`timescale 1ns/1ns
`include "fsf_consts.svh"

module fsf_flag_chain #(
	parameter int DEPTH = `FSF_DEPTH_DEF,
	parameter int DATA_W = `FSF_DATA_W
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Write side
	input wire logic wr_en_n,
	input wire logic [DATA_W-1:0] wr_data,
	// Read side
	input wire logic rd_en_n,
	output logic [DATA_W-1:0] read_data_out,
	// Offset loading
	input wire logic ofs_load,
	input wire logic [`FSF_OFS_W-1:0] ofs_ae_val,
	input wire logic [`FSF_OFS_W-1:0] ofs_af_val,
	// Configuration and chain inputs
	input wire logic depth_expand,
	input wire logic first_in_chain_n,
	input wire logic write_chain_in_n,
	input wire logic read_chain_in_n,
	// Flags and chain outputs
	output logic empty_ind_n,
	output logic full_ind_n,
	output logic almost_empty_n,
	output logic almost_full_n,
	output logic write_chain_out_n,
	output logic read_chain_out_n
);
	import fsf_pkg::*;

	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;
	localparam int OW = `FSF_OFS_W;
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

	function automatic logic [OW-1:0] fsf_def_ofs(input int d);
		if (d <= `FSF_DEPTH_SMALL)
			return OW'(`FSF_OFS_SMALL);
		else if (d <= `FSF_DEPTH_MID)
			return OW'(`FSF_OFS_MID);
		return OW'(`FSF_OFS_LARGE);
	endfunction : fsf_def_ofs

	localparam logic [OW-1:0] OFS_DEF = fsf_def_ofs(DEPTH);

	if (DEPTH < `FSF_DEPTH_MIN || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("DEPTH must be a power of two of at least four.");
	end
	if (DATA_W != `FSF_DATA_W) begin : g_bad_width
		$error("DATA_W must match the write data width.");
	end

	////////////////////////////////////////////////////////////////////////////////

	logic [DATA_W-1:0] mem [DEPTH];
	logic [AW-1:0] wptr_q;
	logic [AW-1:0] rptr_q;
	logic [CW-1:0] count_q;
	logic [CW-1:0] count_d;
	logic [OW-1:0] ae_q;
	logic [OW-1:0] af_q;
	fsf_flags_s flags_q;
	fsf_flags_s flags_d;
	logic wtok_q;
	logic rtok_q;
	logic wchain_q;
	logic rchain_q;
	logic wr_go;
	logic rd_go;

	// Full blocks writes.
	// In a chain only the device that holds the write token accepts data.
	assign wr_go = !wr_en_n && flags_q.full_n && (!depth_expand || wtok_q);
	assign rd_go = !rd_en_n && flags_q.empty_n && (!depth_expand || rtok_q);

	assign count_d = CW'(count_q + CW'(wr_go) - CW'(rd_go));

	always_comb begin
		flags_d.empty_n = count_d != '0;
		flags_d.almost_empty_n = int'(count_d) > int'(ae_q);
		flags_d.half_full_n = !(int'(count_d) > DEPTH / 2);
		flags_d.almost_full_n = !(int'(count_d) >= DEPTH - int'(af_q));
		flags_d.full_n = int'(count_d) != DEPTH;
	end

	////////////////////////////////////////////////////////////////////////////////

	always_ff @(posedge clk_sys) begin
		if (wr_go)
			mem[wptr_q] <= wr_data;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			wptr_q <= '0;
			rptr_q <= '0;
			count_q <= '0;
		end else begin
			if (wr_go)
				wptr_q <= AW'(wptr_q + 1'b1);
			if (rd_go)
				rptr_q <= AW'(rptr_q + 1'b1);
			count_q <= count_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			read_data_out <= '0;
		else if (rd_go)
			read_data_out <= mem[rptr_q];
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ae_q <= OFS_DEF;
			af_q <= OFS_DEF;
		end else if (ofs_load) begin
			ae_q <= ofs_ae_val;
			af_q <= ofs_af_val;
		end
	end

	// Flag reset values.
	// Flags are registered from the next count, so they agree with count_q every cycle.
	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			flags_q <= '{empty_n: 1'b0, almost_empty_n: 1'b0, half_full_n: 1'b1,
				almost_full_n: 1'b1, full_n: 1'b1};
		else
			flags_q <= flags_d;
	end

	// The strap is sampled in the synchronous reset branch, so it is caught while reset holds.
	// An arriving token wins over losing one, which only a one-device loop could cause.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			wtok_q <= !first_in_chain_n;
			rtok_q <= !first_in_chain_n;
		end else begin
			if (wr_go && wptr_q == LAST)
				wtok_q <= 1'b0;
			if (!write_chain_in_n)
				wtok_q <= 1'b1;
			if (rd_go && rptr_q == LAST)
				rtok_q <= 1'b0;
			if (!read_chain_in_n)
				rtok_q <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			wchain_q <= 1'b0;
			rchain_q <= 1'b0;
		end else begin
			wchain_q <= depth_expand && wr_go && wptr_q == LAST;
			rchain_q <= depth_expand && rd_go && rptr_q == LAST;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	assign empty_ind_n = flags_q.empty_n;
	assign full_ind_n = flags_q.full_n;
	assign almost_empty_n = flags_q.almost_empty_n;
	assign almost_full_n = flags_q.almost_full_n;
	assign write_chain_out_n = depth_expand ? !wchain_q : flags_q.half_full_n;
	assign read_chain_out_n = !rchain_q;

	////////////////////////////////////////////////////////////////////////////////

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	property p_empty_tracks;
		(count_q == '0) == !empty_ind_n;
	endproperty
	a_empty_tracks: assert property (p_empty_tracks) else $error("Empty flag disagrees with count.");

	property p_empty_blocks;
		!empty_ind_n && !rd_en_n |=> $stable(read_data_out) && $stable(rptr_q);
	endproperty
	a_empty_blocks: assert property (p_empty_blocks) else $error("Read taken while empty.");

	property p_empty_cause;
		$rose(empty_ind_n) |-> $past(wr_go);
	endproperty
	a_empty_cause: assert property (p_empty_cause) else $error("Empty rose without a write.");

	property p_ae;
		!$past(ofs_load) |-> almost_empty_n == (int'(count_q) > int'(ae_q));
	endproperty
	a_ae: assert property (p_ae) else $error("Almost-empty disagrees with count.");

	property p_af;
		!$past(ofs_load) |-> almost_full_n == (int'(count_q) < DEPTH - int'(af_q));
	endproperty
	a_af: assert property (p_af) else $error("Almost-full disagrees with count.");

	property p_ofs_reset;
		$rose(rst_n) |-> ae_q == OFS_DEF && af_q == OFS_DEF;
	endproperty
	a_ofs_reset: assert property (p_ofs_reset) else $error("Offset default wrong.");

	property p_half;
		!depth_expand |-> write_chain_out_n == !(int'(count_q) > DEPTH / 2);
	endproperty
	a_half: assert property (p_half) else $error("Half-full wrong.");

	property p_wchain;
		depth_expand && wr_go && wptr_q == LAST ##1 depth_expand |->
			!write_chain_out_n ##1 (!depth_expand || write_chain_out_n);
	endproperty
	a_wchain: assert property (p_wchain) else $error("Write chain pulse wrong.");

	property p_rchain;
		depth_expand && rd_go && rptr_q == LAST |=> !read_chain_out_n ##1 read_chain_out_n;
	endproperty
	a_rchain: assert property (p_rchain) else $error("Read chain pulse wrong.");

	property p_full_blocks;
		!full_ind_n && !wr_en_n |=> $stable(wptr_q) && int'(count_q) <= DEPTH;
	endproperty
	a_full_blocks: assert property (p_full_blocks) else $error("Write taken while full.");

	property p_reset_state;
		$rose(rst_n) |-> !empty_ind_n && !almost_empty_n && full_ind_n && almost_full_n
			&& wptr_q == '0 && rptr_q == '0;
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("Reset state wrong.");

	c_full: cover property (!full_ind_n);
	c_wchain: cover property (depth_expand && !write_chain_out_n);
	c_rchain: cover property (!read_chain_out_n);
	c_drain: cover property ($fell(empty_ind_n));
endmodule : fsf_flag_chain

// [include/fsf_consts.svh]
// Constants for the FIFO status flag and depth chain block.
`ifndef FSF_CONSTS_SVH
`define FSF_CONSTS_SVH
`define FSF_DATA_W 18
`define FSF_DEPTH_DEF 256
`define FSF_DEPTH_MIN 4
`define FSF_OFS_W 12
`define FSF_DEPTH_SMALL 256
`define FSF_DEPTH_MID 512
`define FSF_OFS_SMALL 31
`define FSF_OFS_MID 63
`define FSF_OFS_LARGE 127
`endif

// [include/fsf_pkg.sv]
// Types shared by the FIFO status flag and depth chain block.
package fsf_pkg;
	typedef struct packed {
		logic empty_n;
		logic almost_empty_n;
		logic half_full_n;
		logic almost_full_n;
		logic full_n;
	} fsf_flags_s;
endpackage : fsf_pkg

// [bench/fsf_chain_peer.sv]
// Model of the neighbouring device that hands the chain tokens back.
`timescale 1ns/1ns
module fsf_chain_peer #(
	parameter int DLY = 40
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Chain links
	input wire logic depth_expand,
	input wire logic write_chain_out_n,
	input wire logic read_chain_out_n,
	output logic write_chain_in_n,
	output logic read_chain_in_n
);
	int wc;
	int rc;
	// A long delay lets the bench see writes and reads refused without a token.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) wc <= 0;
		else if (!write_chain_out_n) wc <= DLY;
		else if (wc > 0) wc <= wc - 1;
	end
	always_ff @(posedge clk_sys) begin
		if (!rst_n) rc <= 0;
		else if (!read_chain_out_n) rc <= DLY;
		else if (rc > 0) rc <= rc - 1;
	end
	assign write_chain_in_n = depth_expand ? (wc != 1) : 1'b0;
	assign read_chain_in_n = depth_expand ? (rc != 1) : 1'b0;
endmodule : fsf_chain_peer

// [bench/fsf_flag_chain_tb_top.sv]
// Self-checking bench for the FIFO status flag and depth chain block.
`timescale 1ns/1ns
module fsf_flag_chain_tb_top;
	import fsf_pkg::*;
	localparam int D = 256;
	logic clk_sys = 0, rst_n = 0, wr_en_n = 1, rd_en_n = 1, ofs_load = 0, dx = 0, fl = 0;
	logic [17:0] wr_data = 18'h00000, q;
	logic [11:0] aev = 12'h000, afv = 12'h000;
	logic ef, ff, aen, afn, wco, rco, wci, rci;
	int num_errors = 0, cmp_count = 0, cnt = 0, cyc = 0, aeo = 31, afo = 31, i;
	fsf_flags_s sf, xf;
	fsf_flag_chain fsf_flag_chain_inst (.clk_sys(clk_sys), .rst_n(rst_n),
		.wr_en_n(wr_en_n), .wr_data(wr_data), .rd_en_n(rd_en_n), .read_data_out(q),
		.ofs_load(ofs_load), .ofs_ae_val(aev), .ofs_af_val(afv), .depth_expand(dx),
		.first_in_chain_n(fl), .write_chain_in_n(wci), .read_chain_in_n(rci),
		.empty_ind_n(ef), .full_ind_n(ff), .almost_empty_n(aen), .almost_full_n(afn),
		.write_chain_out_n(wco), .read_chain_out_n(rco));
	fsf_chain_peer fsf_chain_peer_inst (.clk_sys(clk_sys), .rst_n(rst_n),
		.depth_expand(dx), .write_chain_out_n(wco), .read_chain_out_n(rco),
		.write_chain_in_n(wci), .read_chain_in_n(rci));
	initial forever #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 6000) begin
			num_errors++;
			finish_test();
		end
	end
	//////////////////////////////////////////////////////////////////////////
	task finish_test;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : finish_test
	task chk(string n, logic [17:0] e, logic [17:0] s);
		cmp_count++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task chk_f;
		sf = '{ef, aen, wco, afn, ff};
		xf = '{cnt != 0, cnt > aeo, dx | (cnt <= D / 2), cnt < D - afo, cnt != D};
		chk("flags", {13'h0000, xf}, {13'h0000, sf});
	endtask : chk_f
	task op(logic w, logic r, logic [17:0] d);
		@(posedge clk_sys);
		wr_en_n <= w;
		rd_en_n <= r;
		wr_data <= d;
		@(posedge clk_sys);
		wr_en_n <= 1'b1;
		rd_en_n <= 1'b1;
		#1;
	endtask : op
	// The strap is sampled during reset, so the mode is set before it.
	task do_reset;
		@(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		#1;
		cnt = 0;
		aeo = 31;
		afo = 31;
	endtask : do_reset
	//////////////////////////////////////////////////////////////////////////
	initial begin
		do_reset();
		chk_f();
		chk("data", 18'h00000, q);
		for (i = 0; i <= D; i++) begin
			op(1'b0, 1'b1, i[17:0]);
			if (cnt < D) cnt++;
			chk_f();
		end
		for (i = 0; i <= D; i++) begin
			op(1'b1, 1'b0, 18'h00000);
			if (cnt > 0) cnt--;
			chk_f();
			chk("data", (i < D) ? i[17:0] : 18'h000FF, q);
			chk("rchain", 18'h00001, {17'h00000, rco});
		end
		$display("single mode fill and drain done");
		@(posedge clk_sys);
		ofs_load <= 1'b1;
		aev <= 12'h002;
		afv <= 12'h0FA;
		@(posedge clk_sys);
		ofs_load <= 1'b0;
		repeat (2) @(posedge clk_sys);
		aeo = 2;
		afo = 250;
		for (i = 0; i < 7; i++) begin
			op(1'b0, 1'b1, 18'h3FFFF);
			cnt++;
			chk_f();
		end
		$display("offset load done");
		dx <= 1'b1;
		do_reset();
		for (i = 0; i < D - 1; i++) begin
			op(1'b0, 1'b1, i[17:0]);
			cnt++;
			chk_f();
		end
		op(1'b0, 1'b1, 18'h000FF);
		cnt++;
		chk("wchain", 18'h00000, {17'h00000, wco});
		@(posedge clk_sys);
		#1;
		chk("wchain", 18'h00001, {17'h00000, wco});
		op(1'b1, 1'b0, 18'h00000);
		cnt--;
		chk("data", 18'h00000, q);
		op(1'b0, 1'b1, 18'h3AAAA);
		chk_f();
		repeat (50) @(posedge clk_sys);
		op(1'b0, 1'b1, 18'h3AAAA);
		cnt++;
		chk_f();
		for (i = 1; i < D; i++) begin
			op(1'b1, 1'b0, 18'h00000);
			cnt--;
			chk("data", i[17:0], q);
		end
		chk("rchain", 18'h00000, {17'h00000, rco});
		@(posedge clk_sys);
		#1;
		chk("rchain", 18'h00001, {17'h00000, rco});
		op(1'b1, 1'b0, 18'h00000);
		chk("data", 18'h000FF, q);
		repeat (50) @(posedge clk_sys);
		op(1'b1, 1'b0, 18'h00000);
		cnt--;
		chk("data", 18'h3AAAA, q);
		chk_f();
		$display("depth mode chain done");
		// A later device in the chain starts without tokens, so its first write is refused.
		fl <= 1'b1;
		do_reset();
		op(1'b0, 1'b1, 18'h15555);
		chk_f();
		$display("chain strap done");
		finish_test();
	end
endmodule : fsf_flag_chain_tb_top
